// ### common/data_space_pkg.sv
// constants for the data space address decoder
package data_space_pkg;
  // ------------------------------------------------------------
  // program memory
  // ------------------------------------------------------------
  localparam int PROG_WORD_W         = 16;
  localparam int PROG_DEPTH_SMALL    = 2048;
  localparam int PROG_DEPTH_LARGE    = 4096;
  localparam int PC_W_SMALL          = 11;
  localparam int PC_W_LARGE          = 12;
  // ------------------------------------------------------------
  // data space map
  // ------------------------------------------------------------
  localparam int DADDR_W             = 16;
  localparam int DATA_W              = 8;
  localparam logic [15:0] GPR_BASE   = 16'h0000;
  localparam int GPR_COUNT           = 32;
  localparam logic [15:0] IO_BASE    = 16'h0020;
  localparam int IO_COUNT            = 64;
  localparam logic [15:0] XIO_BASE   = 16'h0060;
  localparam int XIO_COUNT           = 160;
  localparam logic [15:0] SRAM_BASE  = 16'h0100;
  localparam logic [15:0] SRAM_END_SMALL = 16'h01FF;
  localparam logic [15:0] SRAM_END_LARGE = 16'h02FF;
  localparam int SRAM_BYTES_SMALL    = 256;
  localparam int SRAM_BYTES_LARGE    = 512;
  // ------------------------------------------------------------
  // short i/o addresses
  // ------------------------------------------------------------
  localparam int IO_ADDR_W           = 6;
  localparam logic [5:0] IO_LAST     = 6'h3F;
  localparam logic [5:0] IO_BIT_LAST = 6'h1F;
  localparam logic [5:0] SCRATCH0_IO = 6'h13;
  localparam logic [5:0] SCRATCH1_IO = 6'h14;
  localparam logic [5:0] SCRATCH2_IO = 6'h15;
  localparam logic [7:0] SCRATCH_RST = 8'h00;
  // ------------------------------------------------------------
  // pointers and displacement
  // ------------------------------------------------------------
  localparam logic [4:0] PTR0_LO     = 5'h1A;
  localparam logic [4:0] PTR1_LO     = 5'h1C;
  localparam logic [4:0] PTR2_LO     = 5'h1E;
  localparam int DISP_W              = 6;
  localparam int SRAM_CYCLES         = 2;
  // ------------------------------------------------------------
  // enumerations
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    REGION_NONE = 3'b000,
    REGION_GPR  = 3'b001,
    REGION_IO   = 3'b010,
    REGION_XIO  = 3'b011,
    REGION_SRAM = 3'b100
  } region_t;
  typedef enum logic [2:0] {
    MODE_DIRECT  = 3'b000,
    MODE_IND     = 3'b001,
    MODE_DISP    = 3'b010,
    MODE_PREDEC  = 3'b011,
    MODE_POSTINC = 3'b100,
    MODE_SHORT   = 3'b101
  } amode_t;
  typedef enum logic [2:0] {
    OP_READ  = 3'b000,
    OP_WRITE = 3'b001,
    OP_BSET  = 3'b010,
    OP_BCLR  = 3'b011,
    OP_BTST  = 3'b100
  } op_t;
endpackage

// ### hdl/region_decode.sv
// combinational region decoder for one data space address
`timescale 1ns/1ps
module region_decode #(
  parameter logic [15:0] SRAM_END = 16'h01FF
) (
  input  wire logic [15:0]            addr,
  output data_space_pkg::region_t     region,
  output logic [15:0]                 offset
);
  import data_space_pkg::*;
  always_comb begin
    region = REGION_NONE;
    offset = 16'h0000;
    if (addr < IO_BASE) begin
      region = REGION_GPR;
      offset = addr - GPR_BASE;
    end else if (addr < XIO_BASE) begin
      region = REGION_IO;
      offset = addr - IO_BASE;
    end else if (addr < SRAM_BASE) begin
      region = REGION_XIO;
      offset = addr - XIO_BASE;
    end else if (addr <= SRAM_END) begin
      region = REGION_SRAM;
      offset = addr - SRAM_BASE;
    end
  end
endmodule

// ### hdl/data_space_decoder.sv
// data space decoder, addressing modes, register file and sram
`timescale 1ns/1ps
module data_space_decoder #(
  parameter bit LARGE = 1'b0,
  parameter int PC_W  = LARGE ? data_space_pkg::PC_W_LARGE
                              : data_space_pkg::PC_W_SMALL
) (
  input  wire logic                               clk,
  input  wire logic                               nrst,
  // program memory fetch
  input  wire logic                               pc_load,
  input  wire logic [PC_W-1:0]                    pc_target,
  input  wire logic                               pc_step,
  output logic [PC_W-1:0]                         program_counter,
  output logic [data_space_pkg::PROG_WORD_W-1:0]  instr_word,
  input  wire logic                               prog_wr,
  input  wire logic [PC_W-1:0]                    prog_wr_addr,
  input  wire logic [data_space_pkg::PROG_WORD_W-1:0] prog_wr_data,
  // data access request
  input  wire logic                               req,
  input  wire data_space_pkg::op_t                op,
  input  wire data_space_pkg::amode_t             mode,
  input  wire logic [15:0]                        long_addr,
  input  wire logic [5:0]                         io_addr,
  input  wire logic [1:0]                         ptr_sel,
  input  wire logic [5:0]                         disp,
  input  wire logic [2:0]                         bit_sel,
  input  wire logic [7:0]                         wdata,
  output logic                                    busy,
  output logic                                    done,
  output logic [7:0]                              rdata,
  output logic                                    bit_value,
  output logic                                    illegal,
  output data_space_pkg::region_t                 cur_region,
  // peripheral side
  output logic                                    io_sel,
  output logic                                    xio_sel,
  output logic                                    per_we,
  output logic [7:0]                              per_addr,
  output logic [7:0]                              per_wdata,
  input  wire logic [7:0]                         per_rdata
);
  import data_space_pkg::*;

  localparam logic [15:0] SRAM_END = LARGE ? SRAM_END_LARGE
                                           : SRAM_END_SMALL;
  localparam int SRAM_N = LARGE ? SRAM_BYTES_LARGE : SRAM_BYTES_SMALL;
  localparam int SRAM_AW = $clog2(SRAM_N);
  localparam int PROG_N = LARGE ? PROG_DEPTH_LARGE : PROG_DEPTH_SMALL;

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SRAM = 2'b01
  } phase_t;

  typedef struct packed {
    phase_t          phase;
    logic [PC_W-1:0] pc;
    logic [7:0]      scratch0;
    logic [7:0]      scratch1;
    logic [7:0]      scratch2;
    logic            done;
    logic [7:0]      rdata;
    logic            bitv;
    logic            illegal;
    logic [SRAM_AW-1:0] sram_addr;
    logic            sram_rd;
    logic [PROG_WORD_W-1:0] instr;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // memories stay out of reset; only this word is forced
  localparam state_t STATE_RST = '{
    phase:     ST_IDLE,
    pc:        '0,
    scratch0:  SCRATCH_RST,
    scratch1:  SCRATCH_RST,
    scratch2:  SCRATCH_RST,
    done:      1'b0,
    rdata:     8'h00,
    bitv:      1'b0,
    illegal:   1'b0,
    sram_addr: '0,
    sram_rd:   1'b0,
    instr:     16'h0000
  };

  logic [7:0]  gpr_mem [GPR_COUNT];
  logic [7:0]  sram_mem [SRAM_N];
  logic [PROG_WORD_W-1:0] prog_mem [PROG_N];

  // ------------------------------------------------------------
  // effective address
  // ------------------------------------------------------------
  logic [4:0]  ptr_lo;
  logic [15:0] ptr_val;
  logic [15:0] ea;
  logic [15:0] ptr_new;
  logic        ptr_upd;
  logic        bit_ok;
  region_t     region;
  logic [15:0] offset;

  always_comb begin
    case (ptr_sel)
      2'd1:    ptr_lo = PTR1_LO;
      2'd2:    ptr_lo = PTR2_LO;
      default: ptr_lo = PTR0_LO;
    endcase
  end

  assign ptr_val = {gpr_mem[ptr_lo + 5'd1], gpr_mem[ptr_lo]};

  always_comb begin
    ea      = long_addr;
    ptr_new = ptr_val;
    ptr_upd = 1'b0;
    bit_ok  = 1'b1;
    case (mode)
      MODE_DIRECT:  ea = long_addr;
      MODE_IND:     ea = ptr_val;
      MODE_DISP: begin
        // only the second and third pointers take a displacement
        ea = ptr_val + {10'h000, disp};
        bit_ok = (ptr_sel == 2'd1 || ptr_sel == 2'd2);
      end
      MODE_PREDEC: begin
        // the lowered pointer is already the address of this access
        ptr_new = ptr_val - 16'h0001;
        ea      = ptr_new;
        ptr_upd = 1'b1;
      end
      MODE_POSTINC: begin
        ea      = ptr_val;
        ptr_new = ptr_val + 16'h0001;
        ptr_upd = 1'b1;
      end
      MODE_SHORT: begin
        ea = IO_BASE + {10'h000, io_addr};
        // bit ops reach only the low half of the i/o file
        if (op == OP_BSET || op == OP_BCLR || op == OP_BTST)
          bit_ok = (io_addr <= IO_BIT_LAST);
      end
      default: bit_ok = 1'b0;
    endcase
  end

  region_decode #(
    .SRAM_END (SRAM_END)
  ) u_decode (
    .addr   (ea),
    .region (region),
    .offset (offset)
  );

  // ------------------------------------------------------------
  // scratch register hit
  // ------------------------------------------------------------
  logic [1:0] scr_idx;
  logic       scr_hit;
  logic [7:0] scr_val;
  logic [7:0] old_val;
  logic [7:0] new_val;
  logic       is_wr;

  always_comb begin
    scr_hit = (region == REGION_IO);
    scr_idx = 2'd0;
    case (offset[5:0])
      SCRATCH0_IO: scr_idx = 2'd0;
      SCRATCH1_IO: scr_idx = 2'd1;
      SCRATCH2_IO: scr_idx = 2'd2;
      default:     scr_hit = 1'b0;
    endcase
    case (scr_idx)
      2'd1:    scr_val = state_reg.scratch1;
      2'd2:    scr_val = state_reg.scratch2;
      default: scr_val = state_reg.scratch0;
    endcase
  end

  always_comb begin
    case (region)
      REGION_GPR:  old_val = gpr_mem[offset[4:0]];
      REGION_IO:   old_val = scr_hit ? scr_val : per_rdata;
      REGION_XIO:  old_val = per_rdata;
      default:     old_val = 8'h00;
    endcase
  end

  // ------------------------------------------------------------
  // read-modify-write for the single-bit operations on registers and i/o
  // ------------------------------------------------------------
  always_comb begin
    case (op)
      OP_BSET: new_val = old_val | (8'h01 << bit_sel);
      OP_BCLR: new_val = old_val & ~(8'h01 << bit_sel);
      default: new_val = wdata;
    endcase
    is_wr = (op == OP_WRITE || op == OP_BSET || op == OP_BCLR);
  end

  logic start;
  assign start = req && (state_reg.phase == ST_IDLE) && bit_ok;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    state_next         = state_reg;
    state_next.done    = 1'b0;
    state_next.sram_rd = 1'b0;
    // fetch lags the counter by one cycle
    state_next.instr   = prog_mem[state_reg.pc];
    if (pc_load)
      state_next.pc = pc_target;
    else if (pc_step)
      state_next.pc = state_reg.pc + {{(PC_W-1){1'b0}}, 1'b1};
    case (state_reg.phase)
      ST_IDLE: begin
        // refused requests still answer, so the core never stalls
        if (req && !bit_ok) begin
          state_next.done    = 1'b1;
          state_next.illegal = 1'b1;
          state_next.rdata   = 8'h00;
        end else if (start) begin
          state_next.illegal = 1'b0;
          if (region == REGION_SRAM) begin
            state_next.phase     = ST_SRAM;
            state_next.sram_addr = offset[SRAM_AW-1:0];
            state_next.sram_rd   = !is_wr;
          end else begin
            state_next.done  = 1'b1;
            state_next.rdata = old_val;
            state_next.bitv  = old_val[bit_sel];
            state_next.illegal = (region == REGION_NONE);
            if (is_wr && scr_hit) begin
              case (scr_idx)
                2'd1:    state_next.scratch1 = new_val;
                2'd2:    state_next.scratch2 = new_val;
                default: state_next.scratch0 = new_val;
              endcase
            end
          end
        end
      end
      ST_SRAM: begin
        // second cycle of the sram access ends it
        state_next.phase = ST_IDLE;
        state_next.done  = 1'b1;
        // a write leaves the last read result standing
        if (state_reg.sram_rd) begin
          state_next.rdata = sram_mem[state_reg.sram_addr];
          state_next.bitv  = sram_mem[state_reg.sram_addr][bit_sel];
        end
      end
      default: state_next.phase = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ------------------------------------------------------------
  // memories: no reset, contents undefined at power-up
  // ------------------------------------------------------------
  logic [15:0] sram_off;
  assign sram_off = offset;

  always_ff @(posedge clk) begin
    if (start && is_wr && region == REGION_GPR)
      gpr_mem[offset[4:0]] <= new_val;
    // write-back comes last, so the pointer wins over a data write
    if (start && ptr_upd) begin
      gpr_mem[ptr_lo]        <= ptr_new[7:0];
      gpr_mem[ptr_lo + 5'd1] <= ptr_new[15:8];
    end
    if (start && is_wr && region == REGION_SRAM)
      sram_mem[sram_off[SRAM_AW-1:0]] <= new_val;
    if (prog_wr)
      prog_mem[prog_wr_addr] <= prog_wr_data;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign program_counter = state_reg.pc;
  assign instr_word      = state_reg.instr;
  assign busy            = (state_reg.phase == ST_SRAM);
  assign done            = state_reg.done;
  assign rdata           = state_reg.rdata;
  assign bit_value       = state_reg.bitv;
  assign illegal         = state_reg.illegal;
  assign cur_region      = region;

  // ------------------------------------------------------------
  // peripheral side
  // ------------------------------------------------------------
  // scratch hits stay inside, so the peripherals never see them
  // extended i/o reached through long addresses and pointers, never through short i/o addresses
  always_comb begin
    io_sel    = start && region == REGION_IO && !scr_hit;
    xio_sel   = start && region == REGION_XIO;
    per_we    = (io_sel || xio_sel) && is_wr;
    per_wdata = new_val;
    // the extended file follows the 64 i/o bytes on the address bus
    if (region == REGION_XIO)
      per_addr = offset[7:0] + 8'h40;
    else
      per_addr = {2'b00, offset[5:0]};
  end
endmodule

// ### test/periph_model.sv
// peripheral register file behind the decoder's select strobes
`timescale 1ns/1ps
module periph_model (
  input  wire logic       clk,
  input  wire logic       io_sel,
  input  wire logic       xio_sel,
  input  wire logic       per_we,
  input  wire logic [7:0] per_addr,
  input  wire logic [7:0] per_wdata,
  output logic      [7:0] per_rdata
);
  logic [7:0] mem [256];
  logic [7:0] last_reg = 8'h00;
  logic       sel;
  assign sel = io_sel | xio_sel;
  // unselected bus shows the inverse of the last byte, never stale data
  assign per_rdata = sel ? mem[per_addr] : ~last_reg;
  always @(posedge clk) begin
    if (sel)
      last_reg <= mem[per_addr];
    if (sel && per_we)
      // software never writes reserved i/o, so every write lands
      mem[per_addr] <= per_wdata;
  end
endmodule

// ### test/data_space_decoder_assertions.sv
// concurrent checks on the data space decoder ports
`timescale 1ns/1ps
module dsd_checker #(
  parameter int PC_W = data_space_pkg::PC_W_SMALL
) (
  input wire logic                    clk,
  input wire logic                    nrst,
  input wire logic                    pc_load,
  input wire logic [PC_W-1:0]         pc_target,
  input wire logic                    pc_step,
  input wire logic [PC_W-1:0]         program_counter,
  input wire logic                    req,
  input wire data_space_pkg::op_t     op,
  input wire data_space_pkg::amode_t  mode,
  input wire logic [1:0]              ptr_sel,
  input wire logic                    busy,
  input wire logic                    done,
  input wire logic [7:0]              rdata,
  input wire logic                    illegal,
  input wire data_space_pkg::region_t cur_region,
  input wire logic                    io_sel,
  input wire logic                    xio_sel,
  input wire logic [7:0]              per_addr
);
  import data_space_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------
  // access timing, decode and program counter
  // ----------------------------------------------------------
  a_sram_two_cycle: assert property (
    req && !busy && cur_region == REGION_SRAM
    && !(mode == MODE_DISP && !(ptr_sel inside {2'd1, 2'd2}))
    |=> busy ##1 (done && !busy)
  ) else $error("sram access not done in two cycles");
  a_fast_one_cycle: assert property (
    req && !busy && cur_region != REGION_SRAM |=> done && !busy
  ) else $error("register access not done in one cycle");
  a_unmapped_zero: assert property (
    req && !busy && cur_region == REGION_NONE && op == OP_READ
    |=> illegal && rdata == 8'h00
  ) else $error("unmapped read not flagged as zero");
  a_pc_load_target: assert property (
    pc_load |=> program_counter == $past(pc_target)
  ) else $error("program counter missed its load");
  a_pc_step_inc: assert property (
    !pc_load && pc_step
    |=> program_counter == PC_W'($past(program_counter) + 1'h1)
  ) else $error("program counter missed its step");
  a_io_window: assert property (
    io_sel |-> per_addr <= 8'h3F && !xio_sel
  ) else $error("i/o select outside its window");
  a_xio_window: assert property (
    xio_sel |-> per_addr inside {[8'h40:8'hDF]} && !io_sel
  ) else $error("extended i/o select outside its window");
  a_short_io_region: assert property (
    req && !busy && mode == MODE_SHORT |-> cur_region == REGION_IO
  ) else $error("short address left the i/o file");
endmodule

bind data_space_decoder dsd_checker #(.PC_W(PC_W)) dsd_checker_i (
  .clk(clk), .nrst(nrst), .pc_load(pc_load), .pc_target(pc_target),
  .pc_step(pc_step), .program_counter(program_counter), .req(req),
  .op(op), .mode(mode), .ptr_sel(ptr_sel), .busy(busy), .done(done),
  .rdata(rdata),
  .illegal(illegal), .cur_region(cur_region), .io_sel(io_sel),
  .xio_sel(xio_sel), .per_addr(per_addr)
);

// ### test/testbench.sv
// self-checking bench for the data space decoder
`timescale 1ns/1ps
module testbench;
  import data_space_pkg::*;
  localparam int PC_W = PC_W_SMALL;
  typedef struct packed {
    op_t         o;
    amode_t      m;
    logic [15:0] a;
    logic [7:0]  w;
    logic [7:0]  r;
    logic        il;
    logic [1:0]  lt;
  } row_t;
  logic            clk, nrst, req, pc_load, pc_step, prog_wr;
  logic            busy, done, bit_value, illegal, io_sel, xio_sel, per_we;
  logic [PC_W-1:0] pc_target, prog_wr_addr, program_counter;
  logic [15:0]     prog_wr_data, instr_word;
  logic [7:0]      rdata, per_addr, per_wdata, per_rdata;
  row_t            drv;
  int              lat;
  int              miscompares = 0;
  int              checked = 0;
  // a also carries io addr and disp [5:0], ptr_sel [7:6], bit_sel [10:8]
  row_t rows [26] = '{
    '{OP_WRITE,MODE_DIRECT,16'h0005,8'hA5,8'h00,1'h0,2'h1},
    '{OP_READ,MODE_DIRECT,16'h0005,8'h00,8'hA5,1'h0,2'h1},
    '{OP_WRITE,MODE_SHORT,16'h003F,8'h9E,8'h00,1'h0,2'h1},
    '{OP_READ,MODE_DIRECT,16'h005F,8'h00,8'h9E,1'h0,2'h1},
    '{OP_WRITE,MODE_DIRECT,16'h00C1,8'h77,8'h00,1'h0,2'h1},
    '{OP_READ,MODE_DIRECT,16'h00C1,8'h00,8'h77,1'h0,2'h1},
    '{OP_WRITE,MODE_DIRECT,16'h01FF,8'h22,8'h00,1'h0,2'h2},
    '{OP_READ,MODE_DIRECT,16'h01FF,8'h00,8'h22,1'h0,2'h2},
    '{OP_WRITE,MODE_DIRECT,16'h0200,8'h55,8'h00,1'h1,2'h1},
    '{OP_READ,MODE_DIRECT,16'h0200,8'h00,8'h00,1'h1,2'h1},
    '{OP_WRITE,MODE_SHORT,16'h0013,8'h81,8'h00,1'h0,2'h1},
    '{OP_BSET,MODE_SHORT,16'h0213,8'h00,8'h00,1'h0,2'h1},
    '{OP_BCLR,MODE_SHORT,16'h0713,8'h00,8'h00,1'h0,2'h1},
    '{OP_READ,MODE_DIRECT,16'h0033,8'h00,8'h05,1'h0,2'h1},
    '{OP_BTST,MODE_SHORT,16'h0213,8'h00,8'h01,1'h0,2'h1},
    '{OP_BSET,MODE_SHORT,16'h0020,8'h00,8'h00,1'h1,2'h1},
    '{OP_WRITE,MODE_DIRECT,16'h001A,8'h05,8'h00,1'h0,2'h1},
    '{OP_WRITE,MODE_DIRECT,16'h001B,8'h00,8'h00,1'h0,2'h1},
    '{OP_READ,MODE_IND,16'h0000,8'h00,8'hA5,1'h0,2'h1},
    '{OP_READ,MODE_POSTINC,16'h0000,8'h00,8'hA5,1'h0,2'h1},
    '{OP_READ,MODE_PREDEC,16'h0000,8'h00,8'hA5,1'h0,2'h1},
    '{OP_READ,MODE_DIRECT,16'h001A,8'h00,8'h05,1'h0,2'h1},
    '{OP_WRITE,MODE_DISP,16'h0001,8'h33,8'h00,1'h1,2'h1},
    '{OP_WRITE,MODE_DIRECT,16'h001C,8'hC0,8'h00,1'h0,2'h1},
    '{OP_WRITE,MODE_DIRECT,16'h001D,8'h01,8'h00,1'h0,2'h1},
    '{OP_READ,MODE_DISP,16'h007F,8'h00,8'h22,1'h0,2'h2}
  };

  data_space_decoder #(.LARGE(1'h0), .PC_W(PC_W)) data_space_decoder_i (
    .clk(clk), .nrst(nrst), .pc_load(pc_load), .pc_target(pc_target),
    .pc_step(pc_step), .program_counter(program_counter),
    .instr_word(instr_word), .prog_wr(prog_wr), .prog_wr_addr(prog_wr_addr),
    .prog_wr_data(prog_wr_data), .req(req), .op(drv.o), .mode(drv.m),
    .long_addr(drv.a), .io_addr(drv.a[5:0]), .ptr_sel(drv.a[7:6]),
    .disp(drv.a[5:0]), .bit_sel(drv.a[10:8]), .wdata(drv.w), .busy(busy),
    .done(done), .rdata(rdata), .bit_value(bit_value), .illegal(illegal),
    .cur_region(), .io_sel(io_sel), .xio_sel(xio_sel), .per_we(per_we),
    .per_addr(per_addr), .per_wdata(per_wdata), .per_rdata(per_rdata)
  );
  periph_model periph_model_i (
    .clk(clk), .io_sel(io_sel), .xio_sel(xio_sel), .per_we(per_we),
    .per_addr(per_addr), .per_wdata(per_wdata), .per_rdata(per_rdata)
  );

  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // whole run is under a hundred cycles; this is ample margin
  initial begin
    #50us;
    miscompares++;
    tally_and_finish();
  end

  task automatic chk(input string nm, input logic [15:0] exp,
                     input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic access(input row_t rw);
    @(posedge clk);
    drv <= rw;
    req <= 1'h1;
    @(posedge clk);
    req <= 1'h0;
    lat = 1;
    #1;
    while (done !== 1'h1 && lat < 4) begin
      @(posedge clk);
      #1;
      lat++;
    end
  endtask

  task automatic tally_and_finish();
    if (miscompares == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    nrst = 1'h0;
    drv = '0;
    {req, pc_load, pc_step, prog_wr} = '0;
    {pc_target, prog_wr_addr, prog_wr_data} = '0;
    repeat (5) @(posedge clk);
    #1;
    chk("pc_reset", 16'h0000, 16'(program_counter));
    @(posedge clk);
    nrst <= 1'h1;
    foreach (rows[k]) begin
      access(rows[k]);
      chk("latency", 16'(rows[k].lt), 16'(lat));
      chk("illegal", 16'(rows[k].il), 16'(illegal));
      if (rows[k].o == OP_READ)
        chk("rdata", 16'(rows[k].r), 16'(rdata));
      if (rows[k].o == OP_BTST)
        chk("bit", 16'(rows[k].r[0]), 16'(bit_value));
    end
    // request held through busy must not start a second access
    @(posedge clk);
    drv <= rows[7];
    req <= 1'h1;
    @(posedge clk);
    drv <= '{OP_WRITE,MODE_DIRECT,16'h0005,8'hEE,8'h00,1'h0,2'h1};
    #1;
    chk("busy", 16'h0001, 16'(busy));
    @(posedge clk);
    req <= 1'h0;
    #1;
    chk("busy_done", 16'h0001, 16'(done));
    chk("busy_end", 16'h0000, 16'(busy));
    chk("busy_rdata", 16'h0022, 16'(rdata));
    access(rows[1]);
    chk("refused", 16'h00A5, 16'(rdata));
    // scratch contents must fall back on a mid-run reset
    access('{OP_WRITE,MODE_SHORT,16'h0014,8'hFF,8'h00,1'h0,2'h1});
    @(posedge clk);
    nrst <= 1'h0;
    @(posedge clk);
    nrst <= 1'h1;
    access('{OP_READ,MODE_SHORT,16'h0014,8'h00,8'h00,1'h0,2'h1});
    chk("scratch", {8'h00, SCRATCH_RST}, 16'(rdata));
    // last program word, then a step that wraps the counter
    @(posedge clk);
    prog_wr <= 1'h1;
    prog_wr_addr <= '1;
    prog_wr_data <= 16'hBEEF;
    pc_load <= 1'h1;
    pc_target <= '1;
    @(posedge clk);
    prog_wr <= 1'h0;
    pc_load <= 1'h0;
    pc_step <= 1'h1;
    @(posedge clk);
    pc_step <= 1'h0;
    #1;
    chk("instr_word", 16'hBEEF, instr_word);
    chk("pc_wrap", 16'h0000, 16'(program_counter));
    // let the counter checks on the last step complete
    repeat (2) @(posedge clk);
    tally_and_finish();
  end
endmodule
